// File: src/demand_channel.sv
/*
 One rolling demand element: per-minute average of 5 s samples, circular buffer
 of per-minute averages, running sum and mean, compare against limit.
 Assumes minute_tick only ever coincides with sample_tick.
*/
`timescale 1ns/1ps
module demand_channel import motor_mon_pkg::*; #(
	parameter bit POS_ONLY = 1'b0
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               sample_tick,
	input  wire logic               minute_tick,
	input  wire logic signed [31:0] sample,
	input  wire logic        [6:0]  period,
	input  wire logic        [15:0] limit,
	output logic             [31:0] demand,
	output logic                    over
);

	logic [31:0] mem [DEMAND_MAX];
	logic [35:0] acc_q, acc_d;
	logic [38:0] sum_q, sum_d;
	logic [6:0]  wr_q, wr_d, cnt_q, cnt_d, per_q, per_d, eff;
	logic        upd_q, upd_d;
	logic [31:0] demand_q, demand_d, mag, avg;
	logic        over_q, over_d;

	always_comb begin
		if (period < 7'(DEMAND_MIN))
			eff = 7'(DEMAND_MIN);
		else if (period > 7'(DEMAND_MAX))
			eff = 7'(DEMAND_MAX);
		else
			eff = period;
		if (sample < 0)
			mag = POS_ONLY ? 32'h0 : 32'(-sample);
		else
			mag = 32'(sample);
		avg = 32'((acc_q + 36'(mag)) / 36'(SAMPLES_PER_MIN));
		acc_d = acc_q;
		sum_d = sum_q;
		wr_d = wr_q;
		cnt_d = cnt_q;
		per_d = eff;
		upd_d = 1'b0;
		demand_d = demand_q;
		if (sample_tick)
			acc_d = minute_tick ? ACC_RESET : acc_q + 36'(mag);
		if (per_q != eff) begin
			sum_d = SUM_RESET;
			wr_d = 7'h00;
			cnt_d = 7'h00;
		end else if (minute_tick) begin
			if (cnt_q == eff)
				sum_d = sum_q - 39'(mem[wr_q]) + 39'(avg);
			else begin
				sum_d = sum_q + 39'(avg);
				cnt_d = cnt_q + 7'h01;
			end
			wr_d = (wr_q == eff - 7'h01) ? 7'h00 : wr_q + 7'h01;
			upd_d = 1'b1;
		end
		if (upd_q && cnt_q != 7'h00)
			demand_d = 32'(sum_q / 39'(cnt_q));
		over_d = demand_q >= 32'(limit);
	end

	always_ff @(posedge clk) begin
		if (minute_tick && per_q == eff)
			mem[wr_q] <= avg;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= ACC_RESET;
			sum_q <= SUM_RESET;
			wr_q <= 7'h00;
			cnt_q <= 7'h00;
			per_q <= 7'h00;
			upd_q <= 1'b0;
			demand_q <= DATA_RESET;
			over_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			sum_q <= sum_d;
			wr_q <= wr_d;
			cnt_q <= cnt_d;
			per_q <= per_d;
			upd_q <= upd_d;
			demand_q <= demand_d;
			over_q <= over_d;
		end
	end

	assign demand = demand_q;
	assign over = over_q;

	a_fill_bound: assert property (@(posedge clk) disable iff (!rst_n)
		cnt_q <= per_q) else $error("demand buffer fill exceeds period");

endmodule

// File: src/motor_mon_pkg.sv
/*
 Shared constants, setting types and alarm helper for the motor monitoring block.
 Assumes a 125 MHz system clock; settings arrive as static levels from the host logic.
*/
package motor_mon_pkg;

	localparam int unsigned CLK_HZ          = 125_000_000;
	localparam int unsigned SAMPLE_PERIOD_S = 5;
	localparam int unsigned SAMPLE_CYC      = CLK_HZ * SAMPLE_PERIOD_S;
	localparam int unsigned DELAY_STEP_MS   = 10;
	localparam int unsigned DELAY_STEP_CYC  = CLK_HZ / 1000 * DELAY_STEP_MS;
	localparam int unsigned SAMPLES_PER_MIN = 12;
	localparam int unsigned DELAY_STEPS_MIN = 1;
	localparam int unsigned DELAY_STEPS_MAX = 100;
	localparam int unsigned DEMAND_MIN      = 5;
	localparam int unsigned DEMAND_MAX      = 90;
	localparam int unsigned STARTS_MIN      = 1;
	localparam int unsigned STARTS_MAX      = 5;

	localparam int RLY_ALARM = 0;
	localparam int RLY_AUXILIARY_RELAY_ONE  = 1;
	localparam int RLY_AUXILIARY_RELAY_TWO  = 2;

	localparam logic [35:0] ACC_RESET  = 36'h0;
	localparam logic [38:0] SUM_RESET  = 39'h0;
	localparam logic [31:0] DATA_RESET = 32'h0;

	typedef enum logic [1:0] {MODE_OFF, MODE_LATCHED, MODE_UNLATCHED} alarm_mode_t;
	typedef enum logic {STARTER_BREAKER, STARTER_CONTACTOR} starter_type_t;

	typedef struct packed {
		alarm_mode_t mode;
		logic [2:0]  relays;
	} alarm_cfg_t;

	typedef struct packed {
		alarm_cfg_t  alarm;
		logic [6:0]  period;
		logic [15:0] limit;
	} demand_cfg_t;

	// Next alarm level from mode, current level, cause and reset command
	function automatic logic alarm_next(alarm_mode_t m, logic act, logic cause, logic rst_cmd);
		logic r;
		r = 1'b0;
		case (m)
			MODE_LATCHED:   r = cause | (act & ~rst_cmd);
			MODE_UNLATCHED: r = cause;
			default:        r = 1'b0;
		endcase
		return r;
	endfunction

endpackage

// File: src/motor_monitor.sv
/*
 Motor monitoring alarms: trip counter, starter failure supervision, learned start
 averaging and four rolling demand elements driving alarm and auxiliary relays.
 Assumes settings are static levels, trip_issued and start_event are one-cycle pulses
 from logic on clk, and starter_status arrives asynchronously from a pin.
*/
// Behaviour
// - Trip alarm raised when enabled and trip count reaches pickup level.
// - Trip alarm clears on count cleared, or raised pickup plus reset when latched.
// - Each trip with starter alarm not off starts supervision of starter status input and motor current.
// - Starter alarm if status unchanged or current nonzero at delay expiry.
// - Starter alarm reported as breaker failure or welded contactor by type.
// - Every alarm has modes off, latched, unlatched; off never raises.
// - Unlatched clears with cause; latched needs reset after cause gone.
// - Each alarm drives any chosen mix of alarm, aux one, aux two relays.
// - After programmed starts, one averaged learned record is stored.
// - Per minute, average current and powers from five second samples.
// - Per-minute averages enter a buffer as deep as the demand period.
// - Each minute demand becomes mean magnitude of buffered entries.
// - Real and reactive demand ignore negative samples.
// - Enabled demand element alarms when demand reaches its limit.
`timescale 1ns/1ps
module motor_monitor import motor_mon_pkg::*; #(
	parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
	parameter int unsigned STEP_CYCLES   = DELAY_STEP_CYC
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               reset_cmd,
	input  wire logic        [15:0] trip_count,
	input  wire logic        [15:0] trip_pickup,
	input  wire alarm_cfg_t         trip_cfg,
	input  wire logic               trip_issued,
	input  wire logic               starter_status,
	input  wire alarm_cfg_t         starter_cfg,
	input  wire starter_type_t      starter_type,
	input  wire logic        [6:0]  starter_delay,
	input  wire logic               start_event,
	input  wire logic        [15:0] start_data,
	input  wire logic        [2:0]  starts_to_avg,
	input  wire logic signed [31:0] current_sample,
	input  wire logic signed [31:0] kw_sample,
	input  wire logic signed [31:0] kvar_sample,
	input  wire logic signed [31:0] kva_sample,
	input  wire demand_cfg_t [3:0]  demand_cfg,
	output logic                    trip_alarm,
	output logic                    breaker_failure,
	output logic                    welded_contactor,
	output logic             [3:0]  demand_alarm,
	output logic             [31:0] current_demand,
	output logic                    alarm_relay,
	output logic                    auxiliary_relay_one,
	output logic                    auxiliary_relay_two,
	output logic                    learned_store,
	output logic             [15:0] learned_avg
);

	logic        st_meta_q, st_sync_q;
	logic [31:0] samp_cnt_q, samp_cnt_d;
	logic [3:0]  min_cnt_q, min_cnt_d;
	logic        sample_tick, minute_tick;
	logic        trip_act_q, trip_act_d;
	logic        sf_busy_q, sf_busy_d, sf_ref_q, sf_ref_d, sf_cause_q, sf_cause_d;
	logic        sf_act_q, sf_act_d;
	logic [31:0] sf_cyc_q, sf_cyc_d;
	logic [6:0]  sf_step_q, sf_step_d, sf_steps;
	logic        bf_q, bf_d, wc_q, wc_d;
	logic [3:0]  dem_act_q, dem_act_d, dem_over;
	logic [31:0] dem_val [4];
	logic [2:0]  rly_q, rly_d;
	logic [18:0] ld_sum_q, ld_sum_d;
	logic [2:0]  ld_cnt_q, ld_cnt_d, ld_n;
	logic        ld_st_q, ld_st_d;
	logic [15:0] ld_avg_q, ld_avg_d;
	logic        cur_zero, expire;

	// Status pin into clock domain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_meta_q <= 1'b0;
			st_sync_q <= 1'b0;
		end else begin
			st_meta_q <= starter_status;
			st_sync_q <= st_meta_q;
		end
	end

	// Sample and minute timebase
	assign sample_tick = samp_cnt_q == SAMPLE_CYCLES - 1;
	assign minute_tick = sample_tick && min_cnt_q == 4'(SAMPLES_PER_MIN - 1);
	always_comb begin
		samp_cnt_d = sample_tick ? 32'h0 : samp_cnt_q + 32'h1;
		min_cnt_d = min_cnt_q;
		if (sample_tick)
			min_cnt_d = minute_tick ? 4'h0 : min_cnt_q + 4'h1;
	end

	// Trip counter alarm
	always_comb begin
		trip_act_d = alarm_next(trip_cfg.mode, trip_act_q,
			trip_count >= trip_pickup, reset_cmd);
		if (trip_count == 16'h0000)
			trip_act_d = 1'b0;
	end

	// Starter failure supervision
	assign cur_zero = current_sample == 32'sh0;
	always_comb begin
		if (starter_delay < 7'(DELAY_STEPS_MIN))
			sf_steps = 7'(DELAY_STEPS_MIN);
		else if (starter_delay > 7'(DELAY_STEPS_MAX))
			sf_steps = 7'(DELAY_STEPS_MAX);
		else
			sf_steps = starter_delay;
		expire = sf_busy_q && sf_cyc_q == STEP_CYCLES - 1 && sf_step_q == sf_steps - 7'h01;
		sf_busy_d = sf_busy_q;
		sf_ref_d = sf_ref_q;
		sf_cyc_d = sf_cyc_q;
		sf_step_d = sf_step_q;
		sf_cause_d = sf_cause_q;
		if (trip_issued && starter_cfg.mode != MODE_OFF) begin
			sf_busy_d = 1'b1;
			sf_ref_d = st_sync_q;
			sf_cyc_d = 32'h0;
			sf_step_d = 7'h00;
		end else if (expire) begin
			sf_busy_d = 1'b0;
			sf_cause_d = st_sync_q == sf_ref_q || !cur_zero;
		end else if (sf_busy_q) begin
			sf_cyc_d = (sf_cyc_q == STEP_CYCLES - 1) ? 32'h0 : sf_cyc_q + 32'h1;
			if (sf_cyc_q == STEP_CYCLES - 1)
				sf_step_d = sf_step_q + 7'h01;
		end else if (sf_cause_q && st_sync_q != sf_ref_q && cur_zero)
			sf_cause_d = 1'b0;
		sf_act_d = alarm_next(starter_cfg.mode, sf_act_q, sf_cause_q, reset_cmd);
		bf_d = sf_act_q && starter_type == STARTER_BREAKER;
		wc_d = sf_act_q && starter_type == STARTER_CONTACTOR;
	end

	// Learned start averaging
	always_comb begin
		if (starts_to_avg < 3'(STARTS_MIN))
			ld_n = 3'(STARTS_MIN);
		else if (starts_to_avg > 3'(STARTS_MAX))
			ld_n = 3'(STARTS_MAX);
		else
			ld_n = starts_to_avg;
		ld_sum_d = ld_sum_q;
		ld_cnt_d = ld_cnt_q;
		ld_st_d = 1'b0;
		ld_avg_d = ld_avg_q;
		if (start_event) begin
			if (ld_cnt_q + 3'h1 >= ld_n) begin
				ld_avg_d = 16'((ld_sum_q + 19'(start_data)) / 19'(ld_n));
				ld_st_d = 1'b1;
				ld_sum_d = 19'h0;
				ld_cnt_d = 3'h0;
			end else begin
				ld_sum_d = ld_sum_q + 19'(start_data);
				ld_cnt_d = ld_cnt_q + 3'h1;
			end
		end
	end

	// Demand elements
	demand_channel #(.POS_ONLY(1'b0)) u_dem_cur (.clk(clk), .rst_n(rst_n),
		.sample_tick(sample_tick), .minute_tick(minute_tick), .sample(current_sample),
		.period(demand_cfg[0].period), .limit(demand_cfg[0].limit),
		.demand(dem_val[0]), .over(dem_over[0]));
	demand_channel #(.POS_ONLY(1'b1)) u_dem_kw (.clk(clk), .rst_n(rst_n),
		.sample_tick(sample_tick), .minute_tick(minute_tick), .sample(kw_sample),
		.period(demand_cfg[1].period), .limit(demand_cfg[1].limit),
		.demand(dem_val[1]), .over(dem_over[1]));
	demand_channel #(.POS_ONLY(1'b1)) u_dem_kvar (.clk(clk), .rst_n(rst_n),
		.sample_tick(sample_tick), .minute_tick(minute_tick), .sample(kvar_sample),
		.period(demand_cfg[2].period), .limit(demand_cfg[2].limit),
		.demand(dem_val[2]), .over(dem_over[2]));
	demand_channel #(.POS_ONLY(1'b0)) u_dem_kva (.clk(clk), .rst_n(rst_n),
		.sample_tick(sample_tick), .minute_tick(minute_tick), .sample(kva_sample),
		.period(demand_cfg[3].period), .limit(demand_cfg[3].limit),
		.demand(dem_val[3]), .over(dem_over[3]));

	// Demand alarms and relay mapping
	always_comb begin
		rly_d = 3'b000;
		for (int i = 0; i < 4; i++) begin
			dem_act_d[i] = alarm_next(demand_cfg[i].alarm.mode, dem_act_q[i],
				dem_over[i], reset_cmd);
			if (dem_act_q[i])
				rly_d = rly_d | demand_cfg[i].alarm.relays;
		end
		if (trip_act_q)
			rly_d = rly_d | trip_cfg.relays;
		if (sf_act_q)
			rly_d = rly_d | starter_cfg.relays;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			samp_cnt_q <= 32'h0;
			min_cnt_q <= 4'h0;
			trip_act_q <= 1'b0;
			sf_busy_q <= 1'b0;
			sf_ref_q <= 1'b0;
			sf_cyc_q <= 32'h0;
			sf_step_q <= 7'h00;
			sf_cause_q <= 1'b0;
			sf_act_q <= 1'b0;
			bf_q <= 1'b0;
			wc_q <= 1'b0;
			dem_act_q <= 4'h0;
			rly_q <= 3'b000;
			ld_sum_q <= 19'h0;
			ld_cnt_q <= 3'h0;
			ld_st_q <= 1'b0;
			ld_avg_q <= 16'h0;
		end else begin
			samp_cnt_q <= samp_cnt_d;
			min_cnt_q <= min_cnt_d;
			trip_act_q <= trip_act_d;
			sf_busy_q <= sf_busy_d;
			sf_ref_q <= sf_ref_d;
			sf_cyc_q <= sf_cyc_d;
			sf_step_q <= sf_step_d;
			sf_cause_q <= sf_cause_d;
			sf_act_q <= sf_act_d;
			bf_q <= bf_d;
			wc_q <= wc_d;
			dem_act_q <= dem_act_d;
			rly_q <= rly_d;
			ld_sum_q <= ld_sum_d;
			ld_cnt_q <= ld_cnt_d;
			ld_st_q <= ld_st_d;
			ld_avg_q <= ld_avg_d;
		end
	end

	assign trip_alarm = trip_act_q;
	assign breaker_failure = bf_q;
	assign welded_contactor = wc_q;
	assign demand_alarm = dem_act_q;
	assign current_demand = dem_val[0];
	assign alarm_relay = rly_q[RLY_ALARM];
	assign auxiliary_relay_one = rly_q[RLY_AUXILIARY_RELAY_ONE];
	assign auxiliary_relay_two = rly_q[RLY_AUXILIARY_RELAY_TWO];
	assign learned_store = ld_st_q;
	assign learned_avg = ld_avg_q;

	a_trip_raise: assert property (@(posedge clk) disable iff (!rst_n)
		trip_cfg.mode != MODE_OFF && trip_count != 16'h0 && trip_count >= trip_pickup
		|=> trip_alarm) else $error("trip alarm not raised at pickup");
	a_trip_clear: assert property (@(posedge clk) disable iff (!rst_n)
		trip_count == 16'h0 |=> !trip_alarm) else $error("trip alarm held with zero count");
	a_sf_arm: assert property (@(posedge clk) disable iff (!rst_n)
		trip_issued && starter_cfg.mode != MODE_OFF |=> sf_busy_q && sf_cyc_q == 32'h0)
		else $error("supervision not started on trip");
	a_sf_verdict: assert property (@(posedge clk) disable iff (!rst_n)
		expire && !trip_issued && !cur_zero |=> sf_cause_q)
		else $error("current present at expiry not flagged");
	a_sf_type: assert property (@(posedge clk) disable iff (!rst_n)
		sf_act_q && starter_type == STARTER_CONTACTOR |=> welded_contactor && !breaker_failure)
		else $error("starter alarm reported as wrong type");
	a_off_silent: assert property (@(posedge clk) disable iff (!rst_n)
		demand_cfg[0].alarm.mode == MODE_OFF |=> !dem_act_q[0])
		else $error("alarm raised while off");
	a_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
		sf_act_q && starter_cfg.mode == MODE_LATCHED && !reset_cmd |=> sf_act_q)
		else $error("latched alarm dropped without reset");
	a_relay_drive: assert property (@(posedge clk) disable iff (!rst_n)
		trip_alarm && trip_cfg.relays[RLY_AUXILIARY_RELAY_TWO] |=> auxiliary_relay_two)
		else $error("assigned relay not driven");
	a_store_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		start_event && ld_n == 3'h1 ##1 !start_event |-> learned_store ##1 !learned_store)
		else $error("learned store not a single pulse");
	a_dem_alarm: assert property (@(posedge clk) disable iff (!rst_n)
		demand_cfg[1].alarm.mode == MODE_UNLATCHED && dem_over[1] |=> demand_alarm[1])
		else $error("demand alarm missing at limit");

endmodule

// File: test/starter_model.sv
/*
 Behavioural motor starter: toggles its status contact and drops current after a trip.
 Assumes trip is a one-cycle pulse on clk; respond low models a stuck starter.
*/
`timescale 1ns/1ps
module starter_model (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               trip,
	input  wire logic               respond,
	input  wire logic        [7:0]  op_cycles,
	input  wire logic signed [31:0] run_level,
	output logic                    status,
	output logic signed [31:0]      current
);
	logic [7:0] cnt_q;
	logic       pend_q;
	logic       stop_q;

	// Operates after op_cycles, or never when stuck
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= 8'h00;
			pend_q <= 1'b0;
			stop_q <= 1'b0;
			status <= 1'b0;
		end else if (trip) begin
			cnt_q  <= op_cycles;
			pend_q <= respond;
			stop_q <= stop_q & respond;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end else if (pend_q) begin
			pend_q <= 1'b0;
			stop_q <= 1'b1;
			status <= ~status;
		end
	end

	assign current = stop_q ? 32'sh0 : run_level;
endmodule

// File: test/tb_motor_monitor.sv
/*
 Self-checking bench for motor_monitor with a starter model on the far side.
 Assumes shortened timebase: 4 clocks a sample, 2 clocks a delay step.
*/
`timescale 1ns/1ps
module tb_motor_monitor import motor_mon_pkg::*;;
	logic               clk, rst_n, reset_cmd, trip_issued, starter_status, start_event;
	logic        [15:0] trip_count, trip_pickup, start_data, learned_avg;
	alarm_cfg_t         trip_cfg, starter_cfg;
	starter_type_t      starter_type;
	logic        [6:0]  starter_delay;
	logic        [2:0]  starts_to_avg;
	logic signed [31:0] current_sample, kw_sample, kvar_sample, kva_sample, run_level;
	demand_cfg_t [3:0]  demand_cfg;
	logic               trip_alarm, breaker_failure, welded_contactor, learned_store;
	logic        [3:0]  demand_alarm;
	logic        [31:0] current_demand, prev;
	logic               alarm_relay, auxiliary_relay_one, auxiliary_relay_two, respond;
	int                 num_errors, total_checks;

	motor_monitor #(.SAMPLE_CYCLES(4), .STEP_CYCLES(2)) dut_u (
		.clk(clk), .rst_n(rst_n), .reset_cmd(reset_cmd), .trip_count(trip_count),
		.trip_pickup(trip_pickup), .trip_cfg(trip_cfg), .trip_issued(trip_issued),
		.starter_status(starter_status), .starter_cfg(starter_cfg),
		.starter_type(starter_type), .starter_delay(starter_delay),
		.start_event(start_event), .start_data(start_data), .starts_to_avg(starts_to_avg),
		.current_sample(current_sample), .kw_sample(kw_sample), .kvar_sample(kvar_sample),
		.kva_sample(kva_sample), .demand_cfg(demand_cfg), .trip_alarm(trip_alarm),
		.breaker_failure(breaker_failure), .welded_contactor(welded_contactor),
		.demand_alarm(demand_alarm), .current_demand(current_demand),
		.alarm_relay(alarm_relay), .auxiliary_relay_one(auxiliary_relay_one),
		.auxiliary_relay_two(auxiliary_relay_two), .learned_store(learned_store),
		.learned_avg(learned_avg));

	starter_model starter_u (
		.clk(clk), .rst_n(rst_n), .trip(trip_issued), .respond(respond),
		.op_cycles(8'h02), .run_level(run_level), .status(starter_status),
		.current(current_sample));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic set_trip(input logic [15:0] c, input logic [15:0] p, input logic r);
		trip_count  = c;
		trip_pickup = p;
		reset_cmd   = r;
		cyc(2);
		reset_cmd = 1'b0;
		cyc(1);
	endtask

	task automatic fire_trip(input logic resp, input int n);
		respond     = resp;
		trip_issued = 1'b1;
		cyc(1);
		trip_issued = 1'b0;
		cyc(n);
	endtask

	task automatic start(input logic [15:0] d, input logic last);
		start_data  = d;
		start_event = 1'b1;
		cyc(1);
		if (last)
			start_event = 1'b0;
	endtask

	task automatic wait_demand();
		prev = current_demand;
		for (int i = 0; i < 100 && current_demand === prev; i++)
			cyc(1);
	endtask

	initial begin
		num_errors = 0;
		total_checks = 0;
		rst_n = 1'b0;
		reset_cmd = 1'b0;
		trip_count = 16'h0000;
		trip_pickup = 16'h0003;
		trip_cfg = '{MODE_OFF, 3'h0};
		starter_cfg = '{MODE_OFF, 3'h0};
		trip_issued = 1'b0;
		starter_type = STARTER_BREAKER;
		starter_delay = 7'h03;
		start_event = 1'b0;
		start_data = 16'h0000;
		starts_to_avg = 3'h3;
		respond = 1'b0;
		run_level = 32'sh64;
		kw_sample = -32'sh32;
		kvar_sample = 32'sh28;
		kva_sample = -32'sh50;
		for (int i = 0; i < 4; i++)
			demand_cfg[i] = '{'{MODE_UNLATCHED, 3'h0}, 7'h05, 16'h0096};
		demand_cfg[1].limit = 16'h0001;
		demand_cfg[2].limit = 16'h0032;
		demand_cfg[3].limit = 16'h0050;
		cyc(3);
		rst_n = 1'b1;

		// First minute: partial buffer holds one entry
		wait_demand();
		run_level = 32'sh12C;
		chk("demand first", current_demand, 32'h64);
		cyc(3);
		chk("alarms first", demand_alarm, 4'h8);
		wait_demand();
		chk("demand second", current_demand, 32'hC8);
		cyc(3);
		chk("alarms second", demand_alarm, 4'h9);
		demand_cfg[0].alarm.mode = MODE_OFF;
		demand_cfg[3] = '{'{MODE_LATCHED, 3'h0}, 7'h05, 16'h0051};
		cyc(3);
		chk("alarms off latched", demand_alarm, 4'h8);
		$display("test demand done");

		trip_cfg = '{MODE_UNLATCHED, 3'h1};
		set_trip(16'h0003, 16'h0003, 1'b0);
		chk("trip unl", trip_alarm, 1'b1);
		chk("relay unl", {auxiliary_relay_two, auxiliary_relay_one, alarm_relay}, 3'h1);
		set_trip(16'h0002, 16'h0003, 1'b0);
		chk("trip unl clear", trip_alarm, 1'b0);
		chk("relay clear", alarm_relay, 1'b0);
		trip_cfg = '{MODE_OFF, 3'h1};
		set_trip(16'h0005, 16'h0003, 1'b0);
		chk("trip off", trip_alarm, 1'b0);
		trip_cfg = '{MODE_LATCHED, 3'h6};
		set_trip(16'h0003, 16'h0003, 1'b0);
		chk("relay lat", {auxiliary_relay_two, auxiliary_relay_one, alarm_relay}, 3'h6);
		set_trip(16'h0003, 16'h0003, 1'b1);
		chk("trip lat cause", trip_alarm, 1'b1);
		set_trip(16'h0003, 16'h0004, 1'b0);
		chk("trip lat held", trip_alarm, 1'b1);
		set_trip(16'h0003, 16'h0004, 1'b1);
		chk("trip lat reset", trip_alarm, 1'b0);
		set_trip(16'h0003, 16'h0003, 1'b0);
		set_trip(16'h0000, 16'h0003, 1'b0);
		chk("trip count clear", trip_alarm, 1'b0);
		trip_cfg = '{MODE_OFF, 3'h0};
		cyc(2);
		$display("test trip done");

		fire_trip(1'b0, 15);
		chk("starter off", breaker_failure, 1'b0);
		starter_cfg = '{MODE_UNLATCHED, 3'h2};
		fire_trip(1'b1, 15);
		chk("starter ok", breaker_failure, 1'b0);
		fire_trip(1'b0, 5);
		chk("starter early", breaker_failure, 1'b0);
		cyc(10);
		chk("starter stuck", breaker_failure, 1'b1);
		chk("starter relay", auxiliary_relay_one, 1'b1);
		fire_trip(1'b1, 15);
		chk("starter unl clear", breaker_failure, 1'b0);
		starter_type = STARTER_CONTACTOR;
		fire_trip(1'b0, 15);
		chk("welded", welded_contactor, 1'b1);
		chk("not breaker", breaker_failure, 1'b0);
		starter_cfg = '{MODE_LATCHED, 3'h2};
		fire_trip(1'b1, 15);
		chk("starter lat held", welded_contactor, 1'b1);
		reset_cmd = 1'b1;
		cyc(1);
		reset_cmd = 1'b0;
		cyc(3);
		chk("starter lat reset", welded_contactor, 1'b0);
		$display("test starter done");

		start(16'h000A, 1'b0);
		chk("store early", learned_store, 1'b0);
		start(16'h0014, 1'b0);
		start(16'h0021, 1'b1);
		chk("store third", learned_store, 1'b1);
		chk("avg third", learned_avg, 16'h0015);
		starts_to_avg = 3'h1;
		cyc(1);
		start(16'h0007, 1'b1);
		chk("store one", learned_store, 1'b1);
		chk("avg one", learned_avg, 16'h0007);
		$display("test learned done");
		close_out();
	end

	initial begin
		#40000;
		num_errors++;
		$display("BAD watchdog expected done seen hang");
		close_out();
	end
endmodule
